// *** core/adcsq_pkg.sv ***
package adcsq_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_STS = 12'h000;
  localparam logic [11:0] OFF_IEN = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_CFG1 = 12'h00C;
  localparam logic [11:0] OFF_CHSEL = 12'h028;
  localparam logic [11:0] OFF_DATA = 12'h040;
  localparam logic [11:0] OFF_CCFG = 12'h308;
  localparam int STS_EOC = 2;
  localparam int STS_EOSEQ = 3;
  localparam int CTRL_EN = 0;
  localparam int CTRL_DIS = 1;
  localparam int CTRL_START = 2;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_CAL = 31;
  localparam int CFG_RES_LSB = 3;
  localparam int CFG_ALIGN = 5;
  localparam int CFG_TRG_LSB = 6;
  localparam int CFG_POL_LSB = 10;
  localparam int CFG_REPEAT = 13;
  localparam int CFG_WAIT = 14;
  localparam int CFG_AUTOOFF = 15;
  localparam int CFG_STEP = 16;
  localparam int CCFG_THERM = 23;
  localparam logic [31:0] IEN_MASK = 32'h0000000C;
  localparam logic [31:0] CFG1_MASK = 32'h0001EDF8;
  localparam logic [31:0] CHSEL_MASK = 32'h0007FFFF;
  localparam logic [31:0] CCFG_MASK = 32'h00800000;
  localparam logic [31:0] RST_VALUE = 32'h00000000;
  localparam int CHAN_N = 19;
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [5:0] CYC_RES12 = 6'h0E;
  localparam logic [5:0] CYC_RES10 = 6'h0D;
  localparam logic [5:0] CYC_RES8 = 6'h0B;
  localparam logic [5:0] CYC_RES6 = 6'h09;
  localparam logic [5:0] CAL_CYCLES = 6'h20;
  localparam logic [2:0] TRG_T1_TRGO = 3'h0;
  localparam logic [2:0] TRG_T1_CC4 = 3'h1;
  localparam logic [2:0] TRG_T3_TRGO = 3'h2;
  localparam logic [2:0] TRG_T1_TRGO_ALT = 3'h3;
  localparam logic [2:0] TRG_T15_TRGO = 3'h4;
  localparam logic [2:0] TRG_EXT_PIN = 3'h7;
  localparam logic [1:0] POL_OFF = 2'h0;
  localparam logic [1:0] POL_RISE = 2'h1;
  localparam logic [1:0] POL_FALL = 2'h2;
  localparam logic [1:0] POL_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CONV = 2'b01, ST_CAL = 2'b10} adcsq_state_t;
endpackage

// *** core/adcsq_sequencer.sv ***
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Hardware clears the trim request bit when calibration ends.
// - Calibration factor appears in result bits 6:0 afterwards.
// - No conversion runs while calibration is in progress.
// - Repeat select 0: one pass over channel or group, then stop.
// - Repeat select 1: passes repeat until stopped.
// - Conversion starts on software start bit or selected trigger event.
// - Each conversion writes result, sets done flag, interrupts if enabled.
// - Last channel sets sequence done flag, interrupts if enabled.
// - Stepwise mode converts one next channel per start or trigger.
// - Without stepwise, one start converts whole sequence in order.
// - Channels 0-15 are pins; 16 thermal, 17 reference, 18 battery.
// - Thermal sensor powered only while its common config bit is set.
// - Three-bit source field picks timer outputs or external pin.
// - Polarity 00 off, 01 rising, 10 falling edge.
// - Polarity 11 triggers on both edges.
// - Resolution 12, 10, 8 or 6 bits; lower is shorter.
// - Result left or right aligned in 16-bit result register.
// - Auto shutdown powers converter off whenever idle.
// - Auto delay waits for result read before next conversion.
module adcsq_sequencer
  import adcsq_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [adcsq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adcsq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timerOneTriggerOut,
  input wire logic timerOneCompareFour,
  input wire logic timerThreeTriggerOut,
  input wire logic timerFifteenTriggerOut,
  input wire logic extTriggerPin,
  input wire logic [11:0] sampleValue,
  input wire logic [6:0] trimFactorIn,
  output logic [4:0] channelSelect,
  output logic converterPowerOn,
  output logic sampleActive,
  output logic thermalSensorOn,
  output logic irq
);
  import adcsq_pkg::*;

  // Returns {found, index} of lowest selected channel at or above start
  function automatic logic [5:0] firstFrom(input logic [CHAN_N-1:0] mask, input logic [4:0] from);
    logic [5:0] res;
    res = 6'h00;
    for (int i = CHAN_N - 1; i >= 0; i--)
    begin
      if (mask[i] && (5'(i) >= from))
        res = {1'b1, 5'(i)};
    end
    return res;
  endfunction

  adcsq_state_t state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next;
  logic enable_reg, startBit_reg, calBit_reg, pend_reg, unread_reg;
  logic eocFlag_reg, eoseqFlag_reg;
  logic [31:0] ien_reg, cfg_reg, chsel_reg, ccfg_reg;
  logic [15:0] data_reg;
  logic [4:0] cur_reg, nextFrom_reg;
  logic [4:0] trgSync1_reg, trgSync2_reg;
  logic trgPrev_reg;
  logic awReady_reg, wReady_reg, bValid_reg, arReady_reg, rValid_reg;
  logic [1:0] bResp_reg, rResp_reg;
  logic [31:0] rData_reg;
  logic powerOn_reg, sampleActive_reg, thermOn_reg, irq_reg;
  logic [4:0] chanOut_reg;

  // Bus decode
  wire wrEn = awReady_reg && s_axi_awvalid && wReady_reg && s_axi_wvalid;
  wire rdEn = arReady_reg && s_axi_arvalid;
  wire [31:0] wMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wData = s_axi_wdata & wMask;
  wire wrSts = wrEn && (s_axi_awaddr == OFF_STS);
  wire wrIen = wrEn && (s_axi_awaddr == OFF_IEN);
  wire wrCtrl = wrEn && (s_axi_awaddr == OFF_CTRL);
  wire wrCfg = wrEn && (s_axi_awaddr == OFF_CFG1);
  wire wrChsel = wrEn && (s_axi_awaddr == OFF_CHSEL);
  wire wrCcfg = wrEn && (s_axi_awaddr == OFF_CCFG);
  wire wrHit = wrSts || wrIen || wrCtrl || wrCfg || wrChsel || wrCcfg ||
               (s_axi_awaddr == OFF_DATA);
  wire rdHit = (s_axi_araddr == OFF_STS) || (s_axi_araddr == OFF_IEN) ||
               (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_CFG1) ||
               (s_axi_araddr == OFF_CHSEL) || (s_axi_araddr == OFF_DATA) ||
               (s_axi_araddr == OFF_CCFG);
  wire dataRead = rdEn && (s_axi_araddr == OFF_DATA);

  // Configuration fields
  wire [1:0] resSel = cfg_reg[CFG_RES_LSB +: 2];
  wire alignLeft = cfg_reg[CFG_ALIGN];
  wire [2:0] trgSel = cfg_reg[CFG_TRG_LSB +: 3];
  wire [1:0] polSel = cfg_reg[CFG_POL_LSB +: 2];
  wire repeatMode = cfg_reg[CFG_REPEAT];
  wire autoDelay = cfg_reg[CFG_WAIT];
  wire autoOff = cfg_reg[CFG_AUTOOFF];
  wire stepwise = cfg_reg[CFG_STEP];
  wire [CHAN_N-1:0] chanMask = chsel_reg[CHAN_N-1:0];

  // Control writes; stop and disable abort a running conversion or sequence, not a calibration
  wire disWr = wrCtrl && wData[CTRL_DIS] && enable_reg;
  wire stopWr = wrCtrl && wData[CTRL_STOP];
  wire abort = disWr || stopWr;
  wire swStart = wrCtrl && wData[CTRL_START] && enable_reg && !disWr;
  wire calReq = wrCtrl && wData[CTRL_CAL] && !enable_reg && (state_reg == ST_IDLE);

  // Trigger source select after synchronisers
  wire trgLevel = (trgSel == TRG_T1_TRGO || trgSel == TRG_T1_TRGO_ALT) ? trgSync2_reg[0] :
                  (trgSel == TRG_T1_CC4) ? trgSync2_reg[1] :
                  (trgSel == TRG_T3_TRGO) ? trgSync2_reg[2] :
                  (trgSel == TRG_T15_TRGO) ? trgSync2_reg[3] :
                  (trgSel == TRG_EXT_PIN) ? trgSync2_reg[4] : 1'b0;
  wire trgRise = trgLevel && !trgPrev_reg;
  wire trgFall = !trgLevel && trgPrev_reg;
  wire trgHit = ((polSel == POL_RISE) && trgRise) || ((polSel == POL_FALL) && trgFall) ||
                ((polSel == POL_BOTH) && (trgRise || trgFall));
  wire hwStart = trgHit && startBit_reg && enable_reg && !abort;

  // Sequence walk; stepwise resumes from the saved position
  wire [5:0] fromNext = firstFrom(chanMask, nextFrom_reg);
  wire [5:0] fromZero = firstFrom(chanMask, 5'h00);
  wire [4:0] pickCh = fromNext[5] ? fromNext[4:0] : fromZero[4:0];
  wire [5:0] aboveCur = firstFrom(chanMask, cur_reg + 5'h01);
  wire lastCh = !aboveCur[5];
  wire [5:0] convCycles = (resSel == RES_12) ? CYC_RES12 : (resSel == RES_10) ? CYC_RES10 :
                          (resSel == RES_8) ? CYC_RES8 : CYC_RES6;
  wire convDone = (state_reg == ST_CONV) && (cnt_reg == 6'h01) && !abort;
  wire calDone = (state_reg == ST_CAL) && (cnt_reg == 6'h01);
  // Auto delay holds off while an unread result sits in the register
  wire canStart = pend_reg && enable_reg && fromZero[5] && !(autoDelay && unread_reg);
  wire keepPend = !stepwise && (!lastCh || repeatMode);
  wire endStart = convDone && ((lastCh && !repeatMode && !stepwise) ||
                  (stepwise && (polSel == POL_OFF)));

  // Result truncation and alignment
  wire [11:0] resMask = (resSel == RES_12) ? 12'hFFF : (resSel == RES_10) ? 12'hFFC :
                        (resSel == RES_8) ? 12'hFF0 : 12'hFC0;
  wire [11:0] rawCut = sampleValue & resMask;
  wire [15:0] rightVal = (resSel == RES_12) ? {4'h0, rawCut} :
                         (resSel == RES_10) ? {6'h00, rawCut[11:2]} :
                         (resSel == RES_8) ? {8'h00, rawCut[11:4]} : {10'h000, rawCut[11:6]};
  wire [15:0] resultVal = alignLeft ? {rawCut, 4'h0} : rightVal;

  wire [31:0] ctrlView = {calBit_reg, 26'h0000000, 1'b0, 1'b0, startBit_reg, 1'b0, enable_reg};
  wire [31:0] rdMux = (s_axi_araddr == OFF_STS) ?
                        {28'h0000000, eoseqFlag_reg, eocFlag_reg, 2'h0} :
                      (s_axi_araddr == OFF_IEN) ? ien_reg :
                      (s_axi_araddr == OFF_CTRL) ? ctrlView :
                      (s_axi_araddr == OFF_CFG1) ? cfg_reg :
                      (s_axi_araddr == OFF_CHSEL) ? chsel_reg :
                      (s_axi_araddr == OFF_DATA) ? {16'h0000, data_reg} :
                      (s_axi_araddr == OFF_CCFG) ? ccfg_reg : RST_VALUE;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = (cnt_reg != 6'h00) ? cnt_reg - 6'h01 : 6'h00;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (calReq)
        begin
          state_next = ST_CAL;
          cnt_next = CAL_CYCLES;
        end
        else if (canStart && !abort)
        begin
          state_next = ST_CONV;
          cnt_next = convCycles;
        end
      end
      ST_CONV:
      begin
        if (abort || convDone)
          state_next = ST_IDLE;
      end
      ST_CAL:
      begin
        if (calDone)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 6'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Control bits and sequencing
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      enable_reg <= 1'b0;
      startBit_reg <= 1'b0;
      calBit_reg <= 1'b0;
      pend_reg <= 1'b0;
      cur_reg <= 5'h00;
      nextFrom_reg <= 5'h00;
    end
    else
    begin
      enable_reg <= (enable_reg || (wrCtrl && wData[CTRL_EN] && !calBit_reg)) && !disWr;
      calBit_reg <= (calBit_reg || calReq) && !calDone;
      startBit_reg <= (startBit_reg || swStart) && !abort && !endStart;
      pend_reg <= (convDone ? keepPend : pend_reg) && !abort ||
                  (swStart && (polSel == POL_OFF)) || hwStart;
      if (state_reg == ST_IDLE && state_next == ST_CONV)
        cur_reg <= pickCh;
      if (convDone)
        nextFrom_reg <= lastCh ? 5'h00 : cur_reg + 5'h01;
      else if (abort)
        nextFrom_reg <= 5'h00;
    end
  end

  // Results, flags and the visible configuration
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      data_reg <= 16'h0000;
      unread_reg <= 1'b0;
      eocFlag_reg <= 1'b0;
      eoseqFlag_reg <= 1'b0;
      ien_reg <= RST_VALUE;
      cfg_reg <= RST_VALUE;
      chsel_reg <= RST_VALUE;
      ccfg_reg <= RST_VALUE;
    end
    else
    begin
      if (convDone)
        data_reg <= resultVal;
      else if (calDone)
        data_reg <= {9'h000, trimFactorIn};
      unread_reg <= convDone || (unread_reg && !dataRead);
      // A new event outranks a clear in the same cycle
      eocFlag_reg <= convDone || (eocFlag_reg && !(wrSts && wData[STS_EOC]));
      eoseqFlag_reg <= (convDone && lastCh) ||
                       (eoseqFlag_reg && !(wrSts && wData[STS_EOSEQ]));
      if (wrIen)
        ien_reg <= (ien_reg & ~wMask) | (wData & IEN_MASK);
      // Reconfiguring mid-sequence would scramble the walk, so hold it
      if (wrCfg && !startBit_reg)
        cfg_reg <= (cfg_reg & ~wMask) | (wData & CFG1_MASK);
      if (wrChsel && !startBit_reg)
        chsel_reg <= (chsel_reg & ~wMask) | (wData & CHSEL_MASK);
      if (wrCcfg)
        ccfg_reg <= (ccfg_reg & ~wMask) | (wData & CCFG_MASK);
    end
  end

  // Trigger synchronisers and edge memory
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      trgSync1_reg <= 5'h00;
      trgSync2_reg <= 5'h00;
      trgPrev_reg <= 1'b0;
    end
    else
    begin
      trgSync1_reg <= {extTriggerPin, timerFifteenTriggerOut, timerThreeTriggerOut,
                       timerOneCompareFour, timerOneTriggerOut};
      trgSync2_reg <= trgSync1_reg;
      trgPrev_reg <= trgLevel;
    end
  end

  // Bus handshakes: write waits for address and data together
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      awReady_reg <= 1'b0;
      wReady_reg <= 1'b0;
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b0;
      rResp_reg <= RESP_OKAY;
      rData_reg <= RST_VALUE;
    end
    else
    begin
      awReady_reg <= s_axi_awvalid && s_axi_wvalid && !awReady_reg && !bValid_reg;
      wReady_reg <= s_axi_awvalid && s_axi_wvalid && !awReady_reg && !bValid_reg;
      if (wrEn)
      begin
        bValid_reg <= 1'b1;
        bResp_reg <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bValid_reg <= 1'b0;
      arReady_reg <= s_axi_arvalid && !arReady_reg && !rValid_reg;
      if (rdEn)
      begin
        rValid_reg <= 1'b1;
        rData_reg <= rdMux;
        rResp_reg <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rValid_reg <= 1'b0;
    end
  end

  // Analog side controls and interrupt
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      powerOn_reg <= 1'b0;
      sampleActive_reg <= 1'b0;
      thermOn_reg <= 1'b0;
      irq_reg <= 1'b0;
      chanOut_reg <= 5'h00;
    end
    else
    begin
      powerOn_reg <= (enable_reg || state_next == ST_CAL) &&
                     (!autoOff || state_next != ST_IDLE);
      sampleActive_reg <= (state_next == ST_CONV);
      thermOn_reg <= ccfg_reg[CCFG_THERM];
      irq_reg <= (eocFlag_reg && ien_reg[STS_EOC]) || (eoseqFlag_reg && ien_reg[STS_EOSEQ]);
      if (state_reg == ST_IDLE && state_next == ST_CONV)
        chanOut_reg <= pickCh;
    end
  end

  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;
  assign channelSelect = chanOut_reg;
  assign converterPowerOn = powerOn_reg;
  assign sampleActive = sampleActive_reg;
  assign thermalSensorOn = thermOn_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_cal_selfclear: assert property (calDone |=> !calBit_reg && state_reg == ST_IDLE)
    else $error("trim request not cleared after calibration");
  chk_cal_factor: assert property (calDone |=> data_reg == {9'h000, $past(trimFactorIn)})
    else $error("calibration factor not in result bits");
  chk_no_conv_cal: assert property (state_reg == ST_CAL |-> !sampleActive_reg)
    else $error("conversion active during calibration");
  chk_single_stop: assert property (convDone && lastCh && !repeatMode && !stepwise
    |=> !pend_reg && !startBit_reg)
    else $error("single mode did not stop");
  chk_repeat_go: assert property (convDone && lastCh && repeatMode && !stepwise
    |=> pend_reg)
    else $error("repeat mode did not restart");
  chk_eoc_result: assert property (convDone |=> eocFlag_reg && data_reg == $past(resultVal))
    else $error("conversion done without flag or result");
  chk_eoseq_set: assert property (convDone && lastCh |=> eoseqFlag_reg)
    else $error("sequence done flag missing");
  chk_step_one: assert property (convDone && stepwise |=> !pend_reg || $past(hwStart))
    else $error("stepwise mode ran past one channel");
  chk_rise_once: assert property (polSel == POL_RISE && trgHit |=> !trgHit)
    else $error("one rising edge gave two starts");
  chk_power_off: assert property (autoOff && $stable(autoOff) && state_reg == ST_IDLE &&
    $past(state_reg) == ST_IDLE |-> !powerOn_reg)
    else $error("converter powered while idle in auto shutdown");
  chk_auto_delay: assert property (state_reg == ST_IDLE && autoDelay && unread_reg
    |=> state_reg != ST_CONV)
    else $error("conversion began before result was read");
endmodule // adcsq_sequencer
`default_nettype wire

// *** verification/adcsq_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
module adcsq_partner #(
  parameter logic [6:0] TRIM = 7'h5B
)
(
  input wire logic clock,
  input wire logic [4:0] trigDrive,
  input wire logic [4:0] channelSelect,
  input wire logic sampleActive,
  output logic timerOneTriggerOut,
  output logic timerOneCompareFour,
  output logic timerThreeTriggerOut,
  output logic timerFifteenTriggerOut,
  output logic extTriggerPin,
  output logic [11:0] sampleValue,
  output logic [6:0] trimFactorIn
);
  logic [4:0] lines_reg = 5'h00;
  logic [11:0] answer;
  // Lines move just after an edge, as a timer output would
  always_ff @(posedge clock)
    lines_reg <= trigDrive;
  assign {extTriggerPin, timerFifteenTriggerOut, timerThreeTriggerOut} = lines_reg[4:2];
  assign {timerOneCompareFour, timerOneTriggerOut} = lines_reg[1:0];
  assign answer = {channelSelect, 7'h29};
  // Meaningless outside a conversion, so show the inverse there
  assign sampleValue = sampleActive ? answer : ~answer;
  assign trimFactorIn = TRIM;
endmodule // adcsq_partner
`default_nettype wire

// *** verification/test_adc_conversion_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_adc_conversion_sequencer;
  import adcsq_pkg::*;
  localparam logic [1:0] OK = RESP_OKAY;
  localparam logic [6:0] TRIM = 7'h5B;
  localparam logic [4:0] SEQ [4] = '{5'h00, 5'h05, 5'h10, 5'h12};
  localparam logic [4:0] STEP [3] = '{5'h00, 5'h01, 5'h05};
  localparam logic [2:0] SRC [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  localparam int LINE [6] = '{0, 1, 2, 0, 3, 4};
  localparam logic [5:0] LEN [4] = '{CYC_RES12, CYC_RES10, CYC_RES8, CYC_RES6};
  // Channel 17 sample left aligned; coarser modes drop the low bits
  localparam logic [15:0] LEFT [4] = '{16'h8A90, 16'h8A80, 16'h8A00, 16'h8800};
  localparam logic [11:0] REGS [7] = '{OFF_STS, OFF_IEN, OFF_CTRL, OFF_CFG1,
    OFF_CHSEL, OFF_DATA, OFF_CCFG};
  logic clock = 1'b0, sysRst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [4:0] trigDrive = 5'h00;
  logic awready, wready, bvalid, arready, rvalid, pwrOn, active, thermOn, irq;
  logic tOne, tCc4, tThree, tFifteen, tPin, act_reg;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [11:0] sample;
  logic [6:0] trim;
  logic [4:0] chan, ch_reg;
  int failCount = 0, checksDone = 0, pwrBad = 0, calBad = 0;
  bit calBusy = 0;
  logic [4:0] chanQ [$];
  int lenQ [$];

  adcsq_sequencer adcsq_sequencer_i (
    .clock(clock), .sys_rst(sysRst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timerOneTriggerOut(tOne), .timerOneCompareFour(tCc4), .timerThreeTriggerOut(tThree),
    .timerFifteenTriggerOut(tFifteen), .extTriggerPin(tPin), .sampleValue(sample),
    .trimFactorIn(trim), .channelSelect(chan), .converterPowerOn(pwrOn),
    .sampleActive(active), .thermalSensorOn(thermOn), .irq(irq));

  adcsq_partner #(.TRIM(TRIM)) adcsq_partner_i (
    .clock(clock), .trigDrive(trigDrive), .channelSelect(chan), .sampleActive(active),
    .timerOneTriggerOut(tOne), .timerOneCompareFour(tCc4), .timerThreeTriggerOut(tThree),
    .timerFifteenTriggerOut(tFifteen), .extTriggerPin(tPin), .sampleValue(sample),
    .trimFactorIn(trim));

  always #4 clock = ~clock;

  // One entry per conversion: channel and its busy length
  always @(posedge clock)
  begin
    if (active === 1'b1 && (act_reg !== 1'b1 || chan !== ch_reg))
    begin
      chanQ.push_back(chan);
      lenQ.push_back(1);
    end
    else if (active === 1'b1 && lenQ.size() > 0)
      lenQ[lenQ.size()-1]++;
    if (active === 1'b1 && pwrOn !== 1'b1)
      pwrBad++;
    if (active === 1'b1 && calBusy)
      calBad++;
    act_reg <= active;
    ch_reg <= chan;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One register access; read data lands in rd
  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er);
    bit done = 0;
    @(posedge clock);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    for (int n = 0; n < 100 && !done; n++)
    begin
      @(posedge clock);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if ((w ? bvalid : rvalid) === 1'b1)
      begin
        done = 1;
        bready <= 1'b0;
        rready <= 1'b0;
        rd = rdata;
        chk({30'h0, w ? bresp : rresp}, {30'h0, er});
      end
    end
    if (!done)
      failCount++;
  endtask

  task automatic waitClr(input int b);
    rd = 32'hFFFFFFFF;
    for (int k = 0; k < 300 && rd[b] !== 1'b0; k++)
      bus(0, OFF_CTRL, 32'h0, OK);
    chk({31'h0, rd[b]}, 32'h0);
  endtask

  task automatic clearRuns();
    chanQ.delete();
    lenQ.delete();
  endtask

  task automatic pass(input logic [31:0] cfg, input logic [31:0] mask, input int n,
    input int len);
    bus(1, OFF_STS, 32'hC, OK);
    bus(1, OFF_CFG1, cfg, OK);
    bus(1, OFF_CHSEL, mask, OK);
    clearRuns();
    bus(1, OFF_CTRL, 32'h5, OK);
    waitClr(CTRL_START);
    repeat (40) @(posedge clock);
    chk(chanQ.size(), n);
    foreach (lenQ[i])
      chk(lenQ[i], len);
  endtask

  // Stepwise mode, so every accepted edge shows as one conversion
  task automatic trig(input logic [2:0] src, input logic [1:0] pol, input int ln, input int n);
    bus(1, OFF_CFG1, 32'h10000 | (pol << 10) | (src << 6), OK);
    clearRuns();
    bus(1, OFF_CTRL, 32'h5, OK);
    repeat (30) @(posedge clock);
    trigDrive[ln] <= 1'b1;
    repeat (40) @(posedge clock);
    trigDrive[ln] <= 1'b0;
    repeat (40) @(posedge clock);
    chk(chanQ.size(), n);
    bus(1, OFF_CTRL, 32'h10, OK);
  endtask

  task automatic conclude();
    $display("TB: checks %0d, mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Tests need a few thousand cycles; this bound only catches a hang
  initial
  begin
    repeat (50000) @(posedge clock);
    failCount++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    sysRst <= 1'b0;
    foreach (REGS[i])
    begin
      bus(0, REGS[i], 32'h0, OK);
      chk(rd, 32'h0);
    end
    bus(0, 12'h010, 32'h0, RESP_SLVERR);
    chk(rd, 32'h0);
    bus(1, 12'h010, 32'hFFFFFFFF, RESP_SLVERR);
    calBusy = 1;
    bus(1, OFF_CTRL, 32'h80000000, OK);
    bus(1, OFF_CTRL, 32'h5, OK);
    waitClr(CTRL_CAL);
    calBusy = 0;
    bus(0, OFF_CTRL, 32'h0, OK);
    chk(rd, 32'h0);
    bus(0, OFF_DATA, 32'h0, OK);
    chk(rd, {25'h0, TRIM});
    chk(calBad, 0);
    bus(1, OFF_CTRL, 32'h1, OK);
    bus(1, OFF_IEN, 32'hC, OK);
    pass(32'h0, 32'h50021, 4, CYC_RES12);
    foreach (SEQ[i])
      chk(chanQ[i], SEQ[i]);
    bus(0, OFF_STS, 32'h0, OK);
    chk(rd, 32'hC);
    chk({31'h0, irq}, 32'h1);
    bus(0, OFF_DATA, 32'h0, OK);
    chk(rd, {20'h0, 5'h12, 7'h29});
    bus(1, OFF_IEN, 32'h0, OK);
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, thermOn}, 32'h0);
    bus(1, OFF_CCFG, 32'h00800000, OK);
    repeat (2) @(posedge clock);
    chk({31'h0, thermOn}, 32'h1);
    for (int r = 0; r < 4; r++)
    begin
      pass({27'h0, r[1:0], 3'h0} | 32'h20, 32'h20000, 1, LEN[r]);
      bus(0, OFF_DATA, 32'h0, OK);
      chk(rd, {16'h0, LEFT[r]});
    end
    bus(1, OFF_CFG1, 32'h00010000, OK);
    bus(1, OFF_CHSEL, 32'h23, OK);
    foreach (STEP[i])
    begin
      clearRuns();
      bus(1, OFF_CTRL, 32'h5, OK);
      waitClr(CTRL_START);
      repeat (20) @(posedge clock);
      chk(chanQ.size(), 1);
      chk(chanQ[0], STEP[i]);
    end
    foreach (SRC[i])
      trig(SRC[i], POL_RISE, LINE[i], 1);
    trig(3'h5, POL_RISE, 4, 0);
    trig(TRG_EXT_PIN, POL_OFF, 4, 1);
    trig(TRG_EXT_PIN, POL_FALL, 4, 1);
    trig(TRG_EXT_PIN, POL_BOTH, 4, 2);
    bus(1, OFF_CFG1, 32'h0000A000, OK);
    bus(1, OFF_CHSEL, 32'h3, OK);
    clearRuns();
    bus(1, OFF_CTRL, 32'h5, OK);
    repeat (100) @(posedge clock);
    chk(chanQ.size() > 4, 1);
    bus(1, OFF_CTRL, 32'h10, OK);
    repeat (20) @(posedge clock);
    clearRuns();
    repeat (40) @(posedge clock);
    chk(chanQ.size(), 0);
    chk({31'h0, pwrOn}, 32'h0);
    chk(pwrBad, 0);
    bus(0, OFF_DATA, 32'h0, OK);
    bus(1, OFF_CFG1, 32'h00006000, OK);
    clearRuns();
    bus(1, OFF_CTRL, 32'h5, OK);
    repeat (80) @(posedge clock);
    chk(chanQ.size(), 1);
    bus(0, OFF_DATA, 32'h0, OK);
    repeat (40) @(posedge clock);
    chk(chanQ.size(), 2);
    bus(1, OFF_CTRL, 32'h10, OK);
    bus(1, OFF_CTRL, 32'h2, OK);
    bus(0, OFF_CTRL, 32'h0, OK);
    chk(rd, 32'h0);
    chk({31'h0, pwrOn}, 32'h0);
    conclude();
  end
endmodule // test_adc_conversion_sequencer
`default_nettype wire
